// ===== verilog/eba_ready_arb.sv
// What this block does
// - External ready stretches each bus cycle; its active level is selectable.
// - Synchronous ready is sampled directly; partner drives it to clock reference.
// - Asynchronous ready passes an extra stage, costing at least one waitstate.
// - First ready sample point follows the phases programmed for the cycle.
// - Ready sampled inactive inserts a waitstate and samples again.
// - Ready sampled active ends the running bus cycle.
// - Sample points differ per mode; mandatory waitstates elapse first.
// - Read data latched on the edge raising read strobe.
// - Address changes after strobe end never disturb read result.
// - With arbitration enabled, a hold request releases the bus.
// - The running bus cycle finishes before hold is acknowledged.
// - Release: controls driven inactive, then floated high, latch enable low.
// - Regain: controls driven inactive again before the next bus cycle.
// - Regain starts only on hold going high or arbitration being disabled, never on own request.
// - Hold may drop without own request; bus is then regained normally.
module eba_ready_arb (
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       link_clk_in,
  // Internal master side
  input  wire logic                       req_in,
  input  wire logic                       req_write_in,
  input  wire logic [eba_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [eba_pkg::DATA_W-1:0] req_wdata_in,
  input  wire logic [eba_pkg::WS_W-1:0]   mand_ws_in,
  input  wire logic                       ready_ctrl_in,
  input  wire logic                       ready_async_in,
  input  wire logic                       ready_pol_in,
  input  wire logic                       arb_enable_in,
  output logic                            done_out,
  output logic      [eba_pkg::DATA_W-1:0] rdata_out,
  // External bus pins
  output logic      [eba_pkg::ADDR_W-1:0] addr_out,
  output logic                            ale_out,
  output logic                            rd_n_out,
  output logic                            wr_n_out,
  output logic                            ctrl_oe_out,
  output logic      [eba_pkg::DATA_W-1:0] data_out,
  output logic                            data_oe_out,
  input  wire logic [eba_pkg::DATA_W-1:0] data_in,
  input  wire logic                       ready_pin_in,
  // Arbitration pins, on the link clock
  input  wire logic                       hold_req_n_in,
  output logic                            hold_acknowledge_out,
  output logic                            bus_request_out
);

  import eba_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  eba_state_e          state_r;
  eba_state_e          state_nxt;
  logic [WS_W-1:0]     ws_r;
  logic [WS_W-1:0]     ws_nxt;
  logic                first_r;
  logic                first_nxt;
  logic                write_r;
  logic                write_nxt;
  logic                rdy_sync_r;
  logic                rdy_async;
  logic                rdy_sel;
  logic                rdy_active;
  logic                hold_n_link_r;
  logic                hold_n_core;
  logic                hold_core;
  logic                ack_r;
  logic                bus_request_out_r;
  logic [1:0]          to_link;
  logic [1:0]          at_link;
  logic                link_nrst;
  logic                ack_link_r;
  logic                bus_request_out_link_r;
  logic                accept;
  logic                nxt_cmd;
  logic                nxt_end;

  // ----------------------------------------------------------------
  // Ready sampling
  // ----------------------------------------------------------------
  // direct sample
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdy_sync_r <= 1'b0;
    end else begin
      rdy_sync_r <= ready_pin_in;
    end
  end

  eba_sync #(.WIDTH(1)) u_rdy_sync (
    .clk_in (clk_in),
    .d_in   (ready_pin_in),
    .q_out  (rdy_async)
  );

  assign rdy_sel = ready_async_in ? rdy_async : rdy_sync_r;

  assign rdy_active = (rdy_sel == ready_pol_in);

  // ----------------------------------------------------------------
  // Link domain: hold request in, acknowledge and request out
  // ----------------------------------------------------------------
  // Hold pin is registered on its own clock before it crosses
  eba_sync #(.WIDTH(1)) u_link_rst (
    .clk_in (link_clk_in),
    .d_in   (nrst_in),
    .q_out  (link_nrst)
  );

  always_ff @(posedge link_clk_in) begin
    if (!link_nrst) begin
      hold_n_link_r <= 1'b1;
      ack_link_r    <= 1'b0;
      bus_request_out_link_r   <= 1'b0;
    end else begin
      hold_n_link_r <= hold_req_n_in;
      ack_link_r    <= at_link[0];
      bus_request_out_link_r   <= at_link[1];
    end
  end

  assign hold_acknowledge_out = ack_link_r;
  assign bus_request_out      = bus_request_out_link_r;

  // Levels only cross, so two flops per bit are enough
  eba_sync #(.WIDTH(1)) u_hold_sync (
    .clk_in (clk_in),
    .d_in   (hold_n_link_r),
    .q_out  (hold_n_core)
  );

  assign to_link = {bus_request_out_r, ack_r};

  eba_sync #(.WIDTH(2)) u_ack_sync (
    .clk_in (link_clk_in),
    .d_in   (to_link),
    .q_out  (at_link)
  );

  assign hold_core = arb_enable_in && !hold_n_core;

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // hold is only honoured between cycles
  assign accept = (state_r == ST_IDLE) && !hold_core && req_in;

  always_comb begin
    state_nxt = state_r;
    ws_nxt    = ws_r;
    first_nxt = first_r;
    case (state_r)
      ST_IDLE: begin
        if (hold_core) begin
          state_nxt = ST_REL;
        end else if (req_in) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // programmed phases set first sample point
        state_nxt = ST_CMD;
        ws_nxt    = mand_ws_in;
      end
      ST_CMD: begin
        if (ws_r != WS_RST) begin
          ws_nxt = ws_r - 4'h1;
        end else if (ready_ctrl_in) begin
          state_nxt = ST_RDY;
          first_nxt = 1'b1;
        end else begin
          state_nxt = ST_END;
        end
      end
      ST_RDY: begin
        first_nxt = 1'b0;
        if (first_r && ready_async_in) begin
          state_nxt = ST_RDY;
        end else if (rdy_active) begin
          state_nxt = ST_END;
        end else begin
          state_nxt = ST_RDY;
        end
      end
      ST_END: begin
        state_nxt = ST_IDLE;
      end
      ST_REL: begin
        state_nxt = ST_HELD;
      end
      ST_HELD: begin
        if (!hold_core) begin
          state_nxt = ST_REG;
        end
      end
      ST_REG: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign nxt_cmd = (state_nxt == ST_CMD) || (state_nxt == ST_RDY);
  assign nxt_end = (state_nxt == ST_END);

  // Write drive opens in the latch phase, before write_r has loaded;
  // the stored flag there would echo the previous cycle's direction
  assign write_nxt = accept ? req_write_in : write_r;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      ws_r    <= WS_RST;
      first_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ws_r    <= ws_nxt;
      first_r <= first_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Cycle capture and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      write_r     <= 1'b0;
      addr_out    <= ADDR_RST;
      data_out    <= DATA_RST;
    end else if (accept) begin
      // address held until the next cycle starts
      write_r     <= req_write_in;
      addr_out    <= req_addr_in;
      data_out    <= req_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ale_out     <= 1'b0;
      rd_n_out    <= STROBE_RST;
      wr_n_out    <= STROBE_RST;
      ctrl_oe_out <= OE_RST;
      data_oe_out <= 1'b0;
    end else begin
      // latch enable stays low while released
      ale_out     <= (state_nxt == ST_ADDR);
      rd_n_out    <= !(nxt_cmd && !write_r);
      wr_n_out    <= !(nxt_cmd && write_r);
      ctrl_oe_out <= (state_nxt != ST_HELD);
      data_oe_out <= write_nxt && (nxt_cmd || state_nxt == ST_ADDR);
    end
  end

  // latch with strobe rising edge
  // Sampled before the strobe edge lands, so the partner may let go after
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= DATA_RST;
      done_out  <= 1'b0;
    end else begin
      done_out  <= nxt_end;
      if (nxt_end && !write_r) begin
        rdata_out <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration status
  // ----------------------------------------------------------------
  // acknowledge and request while held
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ack_r  <= 1'b0;
      bus_request_out_r <= 1'b0;
    end else begin
      ack_r  <= (state_nxt == ST_HELD);
      bus_request_out_r <= (state_nxt == ST_HELD) && req_in;
    end
  end

endmodule // eba_ready_arb

// ===== verilog/eba_pkg.sv
package eba_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int WS_W   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST  = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [WS_W-1:0]   WS_RST    = 4'h0;
  localparam logic              STROBE_RST = 1'b1;
  localparam logic              OE_RST     = 1'b1;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  // Extra waitstates forced by the asynchronous ready path
  localparam int ASYNC_EXTRA_WS = 1;
  localparam int SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_RDY,
    ST_END,
    ST_REL,
    ST_HELD,
    ST_REG
  } eba_state_e;

endpackage

// ===== verilog/eba_sync.sv
module eba_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  // First stage is read only by the second to keep metastability local
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    sync_r <= meta_r;
  end

  assign q_out = sync_r;

endmodule // eba_sync

// ===== tb/eba_ready_arb_monitor.sv
module eba_ready_arb_monitor (
  input wire logic                       clk_in,
  input wire logic                       nrst_in,
  input wire logic                       arb_enable_in,
  input wire logic [eba_pkg::DATA_W-1:0] data_in,
  input wire logic                       done_out,
  input wire logic [eba_pkg::DATA_W-1:0] rdata_out,
  input wire logic                       ale_out,
  input wire logic                       rd_n_out,
  input wire logic                       wr_n_out,
  input wire logic                       ctrl_oe_out,
  input wire logic                       data_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------------
  AST_ALE_ONE: assert property (ale_out |=> !ale_out)
    else $error("latch enable wider than one cycle");
  AST_DONE_ONE: assert property (done_out |=> !done_out)
    else $error("done wider than one cycle");
  AST_END_DONE: assert property (
    $rose(rd_n_out) || $rose(wr_n_out) |-> done_out)
    else $error("strobe ended without done");
  AST_RD_DATA: assert property (
    $rose(rd_n_out) |-> rdata_out == $past(data_in))
    else $error("read data not taken at strobe end");
  // Write data must already be driven in the latch phase
  AST_WR_DRIVE: assert property (
    $fell(wr_n_out) |-> data_oe_out && $past(data_oe_out))
    else $error("write data not driven from latch phase");
  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  AST_FLOAT_QUIET: assert property (
    !ctrl_oe_out |-> !ale_out && rd_n_out && wr_n_out)
    else $error("controls active while floated");
  AST_DRIVEN_FIRST: assert property (
    $fell(ctrl_oe_out) |-> $past(rd_n_out) && $past(wr_n_out))
    else $error("float without driving inactive");
  AST_REGAIN: assert property ($rose(ctrl_oe_out) |-> !ale_out [*2])
    else $error("cycle started at regain");
  AST_HELD_IDLE: assert property (!ctrl_oe_out |-> !done_out)
    else $error("cycle ended while held off");
  // Disabled arbitration keeps the bus owned
  AST_ARB_OFF: assert property (!arb_enable_in |-> ctrl_oe_out)
    else $error("bus released with arbitration off");
  cover property ($fell(ctrl_oe_out));
  cover property ($rose(rd_n_out));
  cover property ($rose(wr_n_out));
endmodule // eba_ready_arb_monitor

bind eba_ready_arb eba_ready_arb_monitor i_mon (.*);

// ===== tb/eba_ext_mem.sv
module eba_ext_mem (
  input  wire logic                       clk_in,
  input  wire logic                       rd_n_in,
  input  wire logic                       wr_n_in,
  input  wire logic                       pol_in,
  input  wire logic [3:0]                 lat_in,
  input  wire logic [eba_pkg::ADDR_W-1:0] addr_in,
  output logic      [eba_pkg::DATA_W-1:0] data_out,
  output logic                            ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import eba_pkg::*;
  logic [3:0] cnt_r = 4'h0;
  logic       ready_r = 1'b0;
  logic       strobe;
  assign strobe = !rd_n_in || !wr_n_in;
  // Read data follows the address while the strobe is low, as an
  // asynchronous memory would; the released bus shows the inverse
  assign data_out = (addr_in[DATA_W-1:0] ^ 16'ha5c3) ^ {DATA_W{rd_n_in}};
  // ready on clock, held to strobe end
  always @(posedge clk_in) begin
    cnt_r <= strobe ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
    ready_r <= strobe && cnt_r >= lat_in;
  end
  assign ready_out = ready_r ~^ pol_in;
endmodule // eba_ext_mem

// ===== tb/eba_ready_arb_tb.sv
module eba_ready_arb_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import eba_pkg::*;
  logic              clk_in = 1'b0;
  logic              link_clk_in = 1'b0;
  logic              nrst_in, req_in, req_write_in, ready_ctrl_in;
  logic              ready_async_in, ready_pol_in, arb_enable_in;
  logic              hold_req_n_in, done_out, ale_out, rd_n_out;
  logic              wr_n_out, ctrl_oe_out, data_oe_out, ready_pin_in;
  logic              hold_acknowledge_out, bus_request_out;
  logic [ADDR_W-1:0] req_addr_in, addr_out;
  logic [DATA_W-1:0] req_wdata_in, rdata_out, data_out, data_in;
  logic [WS_W-1:0]   mand_ws_in;
  logic [3:0]        lat;
  int                err_count = 0, check_count = 0, waited;

  always #2.5 clk_in = ~clk_in;
  initial #1.3 forever #7.5 link_clk_in = ~link_clk_in;

  eba_ready_arb i_dut (.*);
  eba_ext_mem i_mem (.clk_in, .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .pol_in(ready_pol_in), .lat_in(lat), .addr_in(addr_out),
    .data_out(data_in), .ready_out(ready_pin_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] mem_word(logic [ADDR_W-1:0] a);
    return a[DATA_W-1:0] ^ 16'ha5c3;
  endfunction

  function automatic logic pick(int w);
    case (w)
      0: return done_out;
      1: return ctrl_oe_out;
      2: return hold_acknowledge_out;
      default: return bus_request_out;
    endcase
  endfunction

  task automatic chk(bit ok, string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_on(int w, logic v, int lim);
    waited = 0;
    while (pick(w) !== v && waited < lim) begin
      @(posedge clk_in);
      #1;
      waited++;
    end
    if (pick(w) !== v) begin
      chk(1'b0, "wait ran out");
      final_report();
    end
  endtask

  task automatic run_cycle(logic w, logic [WS_W-1:0] n, logic rc, logic as);
    req_write_in = w;
    req_addr_in = ADDR_W'($urandom);
    req_wdata_in = DATA_W'($urandom);
    mand_ws_in = n;
    ready_ctrl_in = rc;
    ready_async_in = as;
    ready_pol_in = 1'($urandom);
    lat = 4'($urandom_range(4));
    req_in = 1'b1;
    wait_on(0, 1'b1, 200);
    req_in = 1'b0;
    if (!rc) chk(waited == 3 + n, "cycle length");
    // Sync ready costs one sample flop; async one cycle more, from its second flop or the forced wait
    if (rc) chk(waited == (n > lat ? 4 + n : 5 + lat) + as, "ready");
    if (!w) chk(rdata_out === mem_word(req_addr_in), "read data");
    if (w) chk(data_out === req_wdata_in, "write data");
    chk(addr_out === req_addr_in, "address held");
    @(posedge clk_in);
    #1;
  endtask

  // Hold arrives mid cycle; optional own request while held off
  task automatic hold_test(logic need);
    req_write_in = 1'b0;
    mand_ws_in = 4'h7;
    ready_ctrl_in = 1'b0;
    req_in = 1'b1;
    @(posedge link_clk_in);
    #1;
    hold_req_n_in = 1'b0;
    wait_on(0, 1'b1, 60);
    req_in = 1'b0;
    chk(ctrl_oe_out === 1'b1, "bus left mid cycle");
    wait_on(2, 1'b1, 80);
    chk(ctrl_oe_out === 1'b0, "bus not floated");
    req_in = need;
    if (need) begin
      wait_on(3, 1'b1, 40);
      repeat (10) @(posedge clk_in);
      #1;
      chk(ctrl_oe_out === 1'b0, "regain on own request");
    end else begin
      chk(bus_request_out === 1'b0, "request unneeded");
    end
    @(posedge link_clk_in);
    #1;
    hold_req_n_in = 1'b1;
    wait_on(1, 1'b1, 80);
    chk(rd_n_out === 1'b1 && ale_out === 1'b0, "regain not inactive");
    wait_on(2, 1'b0, 80);
    if (need) begin
      wait_on(0, 1'b1, 60);
      req_in = 1'b0;
      chk(rdata_out === mem_word(req_addr_in), "read after regain");
    end
    chk(ctrl_oe_out === 1'b1, "bus not regained");
    @(posedge clk_in);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_in, req_in, req_write_in, ready_ctrl_in, ready_async_in} = '0;
    {ready_pol_in, mand_ws_in, lat, req_addr_in, req_wdata_in} = '0;
    arb_enable_in = 1'b1;
    hold_req_n_in = 1'b1;
    void'($urandom(98));
    // Long enough for four link edges as well
    repeat (13) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    run_cycle(1'b0, 4'hf, 1'b0, 1'b0);
    run_cycle(1'b1, 4'h0, 1'b0, 1'b0);
    run_cycle(1'b0, 4'h0, 1'b1, 1'b1);
    repeat (24) run_cycle(1'($urandom), 4'($urandom_range(3)),
                          1'($urandom), 1'($urandom));
    hold_test(1'b1);
    hold_test(1'b0);
    arb_enable_in = 1'b0;
    hold_req_n_in = 1'b0;
    run_cycle(1'b0, 4'h1, 1'b0, 1'b0);
    hold_req_n_in = 1'b1;
    final_report();
  end
endmodule // eba_ready_arb_tb
